// ===== hdl/wdx_cfg.svh
// Register offsets, field positions, reset values and opcodes of the wide write command block
// Assumes inclusion by bare name from the package and the top module
`ifndef WDX_CFG_SVH
`define WDX_CFG_SVH

// ----------------------------------------
// Register offsets (taskfile port)
// ----------------------------------------
`define WDX_OFS_DATA 4'h0
`define WDX_OFS_ERROR 4'h1
`define WDX_OFS_COUNT 4'h2
`define WDX_OFS_ADDR_LOW 4'h3
`define WDX_OFS_ADDR_MID 4'h4
`define WDX_OFS_ADDR_HIGH 4'h5
`define WDX_OFS_DRIVE 4'h6
`define WDX_OFS_STATUS 4'h7
`define WDX_OFS_CONTROL 4'h8
`define WDX_OFS_MEDIA 4'h9
// ----------------------------------------
// Field positions
// ----------------------------------------
`define WDX_ST_BUSY 7
`define WDX_ST_READY 6
`define WDX_ST_FAULT 5
`define WDX_ST_DREQ 3
`define WDX_ST_ERR 0
`define WDX_ER_CKSUM 7
`define WDX_ER_WPROT 6
`define WDX_ER_MCHG 5
`define WDX_ER_NOTFOUND 4
`define WDX_ER_MCREQ 3
`define WDX_ER_ABORT 2
`define WDX_ER_NOMEDIA 1
`define WDX_DRV_SEL 4
`define WDX_DRV_LOGICAL 6
`define WDX_CTL_BYTE_SEL 7
`define WDX_MED_PRESENT 0
`define WDX_MED_WPROT 1
`define WDX_MED_REMOVABLE 2
`define WDX_MED_CHANGED 3
`define WDX_MED_CHREQ 4
// ----------------------------------------
// Opcodes and reset values
// ----------------------------------------
`define WDX_OP_WRITE_EXT 8'h35
`define WDX_OP_MEDIA_STATE 8'hda
`define WDX_RST_STATUS 8'h40
`define WDX_RST_DRIVE 8'h00
`define WDX_MAX_LBA 48'h0000_ffff_ffff
`define WDX_UNIT_ID 1'b0
`define WDX_PACKET_SET 1'b0
`endif

// ===== hdl/wdx_pkg.sv
// Types shared by the wide write command block
// Assumes the config header on the include path
package wdx_pkg;
    `include "wdx_cfg.svh"

    typedef enum logic [1:0] {
        WDX_IDLE = 2'b00,
        WDX_CHECK = 2'b01,
        WDX_XFER = 2'b10
    } wdx_state_t;

    typedef struct packed {
        logic [7:0] cur;
        logic [7:0] prev;
    } wdx_pair_t;
endpackage

// ===== hdl/wdx_pair_reg.sv
// Two-byte taskfile register: current byte and the byte it displaced
// Assumes synchronous active-low reset and one write strobe per cycle
`timescale 1ns/1ps
module wdx_pair_reg
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic wr_i,
    input wire logic [7:0] data_i,
    input wire logic load_i,
    input wire logic [15:0] load_data_i,
    output wdx_pkg::wdx_pair_t pair_o
);
    import wdx_pkg::*;

    wdx_pair_t state_q;
    wdx_pair_t state_d;

    always_comb
    begin
        state_d = state_q;
        if (load_i)
        begin
            state_d.prev = load_data_i[15:8];
            state_d.cur = load_data_i[7:0];
        end
        else if (wr_i)
        begin
            state_d.prev = state_q.cur;
            state_d.cur = data_i;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            state_q <= '0;
        else
            state_q <= state_d;
    end

    assign pair_o = state_q;
endmodule

// ===== hdl/wdx_core.sv
// Device-side interpreter of the extended-address DMA write command
// Assumes a plain register port and a DMA engine that reports sector progress and errors
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "wdx_cfg.svh"
module wdx_core
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic media_present_i,
    input wire logic media_wprot_i,
    input wire logic media_change_i,
    input wire logic media_chreq_i,
    input wire logic dma_ultra_i,
    input wire logic sector_done_i,
    input wire logic xfer_cksum_err_i,
    input wire logic xfer_udma_err_i,
    input wire logic xfer_media_err_i,
    input wire logic dev_fault_i,
    output logic dma_run_o,
    output logic [47:0] xfer_lba_o,
    output logic [16:0] xfer_count_o
);
    import wdx_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        wdx_state_t st;
        logic [7:0] status;
        logic [7:0] error;
        logic drv_sel;
        logic logical;
        logic byte_sel;
        logic mchg_seen;
        logic mcreq;
        logic [47:0] lba;
        logic [16:0] left;
        logic run;
        logic [7:0] rdata;
    } wdx_core_t;

    wdx_core_t s_q;
    wdx_core_t s_d;

    wdx_pair_t pair_w [0:3];
    logic [3:0] pwr_w;
    logic load_w;
    logic [15:0] cnt16_w;
    logic [47:0] start_w;
    logic [7:0] err_v;

    // ----------------------------------------
    // Input register pairs
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_pair
            assign pwr_w[gi] = reg_wr_i && (reg_addr_i == (`WDX_OFS_COUNT + 4'(gi)));
            wdx_pair_reg u_pair
            (
                .clk_sys_i(clk_sys_i),
                .reset_n_i(reset_n_i),
                .wr_i(pwr_w[gi]),
                .data_i(reg_wdata_i),
                .load_i(load_w && (gi != 0)),
                .load_data_i(gi == 1 ? {s_q.lba[31:24], s_q.lba[7:0]} :
                             gi == 2 ? {s_q.lba[39:32], s_q.lba[15:8]} :
                                       {s_q.lba[47:40], s_q.lba[23:16]}),
                .pair_o(pair_w[gi])
            );
        end
    endgenerate

    assign cnt16_w = {pair_w[0].prev, pair_w[0].cur};
    assign start_w = {pair_w[3].prev, pair_w[2].prev, pair_w[1].prev,
                      pair_w[3].cur, pair_w[2].cur, pair_w[1].cur};
    assign load_w = (s_q.st == WDX_XFER) && xfer_media_err_i;

    // ----------------------------------------
    // Command sequencing
    // ----------------------------------------
    always_comb
    begin
        err_v = 8'h00;
        s_d = s_q;
        if (media_change_i)
            s_d.mchg_seen = 1'b1;
        if (media_chreq_i)
            s_d.mcreq = 1'b1;
        if (reg_wr_i && reg_addr_i == `WDX_OFS_DRIVE)
        begin
            s_d.drv_sel = reg_wdata_i[`WDX_DRV_SEL];
            s_d.logical = reg_wdata_i[`WDX_DRV_LOGICAL];
        end
        if (reg_wr_i && reg_addr_i == `WDX_OFS_CONTROL)
            s_d.byte_sel = reg_wdata_i[`WDX_CTL_BYTE_SEL];
        case (s_q.st)
            WDX_IDLE:
            begin
                if (reg_wr_i && reg_addr_i == `WDX_OFS_STATUS && s_q.drv_sel == `WDX_UNIT_ID)
                begin
                    s_d.status = 8'h00;
                    s_d.status[`WDX_ST_BUSY] = 1'b1;
                    s_d.error = 8'h00;
                    if (reg_wdata_i == `WDX_OP_MEDIA_STATE)
                    begin
                        s_d.mcreq = media_chreq_i;
                        s_d.status = `WDX_RST_STATUS;
                    end
                    else if (reg_wdata_i == `WDX_OP_WRITE_EXT && !`WDX_PACKET_SET)
                        s_d.st = WDX_CHECK;
                    else
                    begin
                        s_d.error[`WDX_ER_ABORT] = 1'b1;
                        s_d.status = `WDX_RST_STATUS;
                        s_d.status[`WDX_ST_ERR] = 1'b1;
                    end
                end
            end
            WDX_CHECK:
            begin
                s_d.lba = start_w;
                s_d.left = (cnt16_w == 16'h0000) ? 17'h10000 : {1'b0, cnt16_w};
                s_d.mcreq = media_chreq_i;
                err_v[`WDX_ER_NOMEDIA] = !media_present_i;
                err_v[`WDX_ER_WPROT] = media_present_i && media_wprot_i;
                err_v[`WDX_ER_MCHG] = s_q.mchg_seen || media_change_i;
                err_v[`WDX_ER_MCREQ] = s_q.mcreq || media_chreq_i;
                if (start_w > `WDX_MAX_LBA)
                    err_v[`WDX_ER_NOTFOUND] = 1'b1;
                if (err_v[`WDX_ER_MCHG])
                    s_d.mchg_seen = 1'b0;
                if (err_v != 8'h00)
                begin
                    s_d.error = err_v;
                    s_d.st = WDX_IDLE;
                    s_d.status = `WDX_RST_STATUS;
                    s_d.status[`WDX_ST_ERR] = 1'b1;
                end
                else
                begin
                    s_d.st = WDX_XFER;
                    s_d.run = 1'b1;
                end
            end
            WDX_XFER:
            begin
                if (xfer_media_err_i || xfer_udma_err_i || xfer_cksum_err_i || dev_fault_i)
                begin
                    err_v[`WDX_ER_CKSUM] = xfer_cksum_err_i && dma_ultra_i;
                    err_v[`WDX_ER_ABORT] = dma_ultra_i && (xfer_cksum_err_i || xfer_udma_err_i);
                    err_v[`WDX_ER_NOTFOUND] = xfer_media_err_i;
                    s_d.error = err_v;
                    s_d.run = 1'b0;
                    s_d.st = WDX_IDLE;
                    s_d.status = `WDX_RST_STATUS;
                    s_d.status[`WDX_ST_FAULT] = dev_fault_i;
                    s_d.status[`WDX_ST_ERR] = (err_v != 8'h00);
                end
                else if (sector_done_i)
                begin
                    s_d.lba = s_q.lba + 48'h1;
                    s_d.left = s_q.left - 17'h1;
                    if (s_q.left == 17'h1)
                    begin
                        s_d.run = 1'b0;
                        s_d.st = WDX_IDLE;
                        s_d.status = `WDX_RST_STATUS;
                    end
                end
            end
            default:
            begin
                s_d.st = WDX_IDLE;
            end
        endcase
        // ----------------------------------------
        // Read port
        // ----------------------------------------
        s_d.rdata = 8'h00;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `WDX_OFS_ERROR: s_d.rdata = s_q.error;
                `WDX_OFS_COUNT: s_d.rdata = s_q.byte_sel ? pair_w[0].prev : pair_w[0].cur;
                `WDX_OFS_ADDR_LOW: s_d.rdata = s_q.byte_sel ? pair_w[1].prev : pair_w[1].cur;
                `WDX_OFS_ADDR_MID: s_d.rdata = s_q.byte_sel ? pair_w[2].prev : pair_w[2].cur;
                `WDX_OFS_ADDR_HIGH: s_d.rdata = s_q.byte_sel ? pair_w[3].prev : pair_w[3].cur;
                `WDX_OFS_DRIVE: s_d.rdata = {1'b0, s_q.logical, 1'b0, s_q.drv_sel, 4'h0};
                `WDX_OFS_STATUS: s_d.rdata = s_q.status;
                `WDX_OFS_CONTROL: s_d.rdata = {s_q.byte_sel, 7'h00};
                `WDX_OFS_MEDIA: s_d.rdata = {3'h0, s_q.mcreq, s_q.mchg_seen, 1'b1, media_wprot_i, media_present_i};
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            s_q <= '0;
            s_q.st <= WDX_IDLE;
            s_q.status <= `WDX_RST_STATUS;
        end
        else
            s_q <= s_d;
    end

    assign reg_rdata_o = s_q.rdata;
    assign dma_run_o = s_q.run;
    assign xfer_lba_o = s_q.lba;
    assign xfer_count_o = s_q.left;
endmodule

// ===== tb/wdx_core_asserts.sv
// Checker of the wide write command block
// Assumes a bind to wdx_core and one clock domain
`timescale 1ns/1ps
`include "wdx_cfg.svh"
module wdx_core_asserts
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic sector_done_i,
    input wire logic xfer_cksum_err_i,
    input wire logic xfer_udma_err_i,
    input wire logic xfer_media_err_i,
    input wire logic dev_fault_i,
    input wire logic dma_run_o,
    input wire logic [47:0] xfer_lba_o,
    input wire logic [16:0] xfer_count_o
);
    wire logic er = xfer_cksum_err_i | xfer_udma_err_i | xfer_media_err_i | dev_fault_i;
    wire logic ev = er | sector_done_i;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_rd_st;
        reg_rd_i && reg_addr_i == `WDX_OFS_STATUS;
    endsequence
    sequence s_fin;
        $fell(dma_run_o) ##[0:3] s_rd_st;
    endsequence
    property p_rd_idle;
        !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
    endproperty
    property p_run_start;
        $rose(dma_run_o) |-> $past(reg_wr_i && reg_addr_i == `WDX_OFS_STATUS && reg_wdata_i == 8'h35, 2);
    endproperty
    property p_run_end;
        $fell(dma_run_o) |-> $past(ev);
    endproperty
    property p_run_hold;
        dma_run_o && !ev |=> dma_run_o;
    endproperty
    property p_count_nz;
        $rose(dma_run_o) |-> xfer_count_o != 17'h0 && xfer_count_o <= 17'h10000;
    endproperty
    property p_step;
        dma_run_o && sector_done_i && !er && xfer_count_o > 17'h1 |=>
            xfer_count_o == $past(xfer_count_o) - 17'h1 && xfer_lba_o == $past(xfer_lba_o) + 48'h1;
    endproperty
    property p_busy_run;
        s_rd_st ##0 dma_run_o |=> reg_rdata_o[7];
    endproperty
    property p_done_st;
        s_fin |=> reg_rdata_o[7:6] == 2'b01 && !reg_rdata_o[3];
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    a_run_start: assert property (p_run_start) else $error("transfer without command");
    a_run_end: assert property (p_run_end) else $error("transfer stopped without cause");
    a_run_hold: assert property (p_run_hold) else $error("transfer dropped");
    a_count_nz: assert property (p_count_nz) else $error("bad sector count");
    a_step: assert property (p_step) else $error("bad sector step");
    a_busy_run: assert property (p_busy_run) else $error("busy clear in transfer");
    a_done_st: assert property (p_done_st) else $error("bad end status");
endmodule
bind wdx_core wdx_core_asserts u_chk (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .sector_done_i(sector_done_i), .xfer_cksum_err_i(xfer_cksum_err_i), .xfer_udma_err_i(xfer_udma_err_i),
    .xfer_media_err_i(xfer_media_err_i), .dev_fault_i(dev_fault_i), .dma_run_o(dma_run_o),
    .xfer_lba_o(xfer_lba_o), .xfer_count_o(xfer_count_o));

// ===== tb/wdx_dma_model.sv
// Far-side data mover: one sector per gap, optional media fault
// Assumes the run level and sectors-left count of wdx_core
`timescale 1ns/1ps
module wdx_dma_model
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic run_i,
    input wire logic [3:0] gap_i,
    input wire logic [16:0] left_i,
    input wire logic [16:0] fail_at_i,
    output logic done_o,
    output logic fail_o
);
    logic [3:0] wait_q;
    always_ff @(posedge clk_sys_i)
    begin
        done_o <= 1'b0;
        fail_o <= 1'b0;
        if (!reset_n_i || !run_i || done_o || fail_o)
            wait_q <= 4'h0;
        else if (wait_q != gap_i)
            wait_q <= wait_q + 4'h1;
        else if (left_i == fail_at_i)
            fail_o <= 1'b1;
        else
            done_o <= 1'b1;
    end
endmodule

// ===== tb/wdx_core_bench.sv
// Testbench of the wide write command block
// Assumes the checker bound and the far-side model beside it
`timescale 1ns/1ps
module wdx_core_bench;
    import wdx_pkg::*;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, c;
    logic wr = 1'b0, rd = 1'b0, rd_q = 1'b0, done, merr, run;
    logic pres = 1'b1, wp = 1'b0, chg = 1'b0, creq = 1'b0, ultra = 1'b0, ck = 1'b0, ue = 1'b0, flt = 1'b0;
    logic [3:0] gap = 4'h0;
    logic [16:0] fail_at = 17'h0, cnt;
    logic [47:0] lba, f;
    logic [7:0] b [6];
    logic [15:0] pv [4];
    logic [7:0] errs [8] = '{8'h04, 8'h40, 8'h02, 8'h08, 8'h20, 8'h84, 8'h04, 8'h00};
    logic [7:0] sts [8] = '{8'h41, 8'h41, 8'h41, 8'h41, 8'h41, 8'h41, 8'h61, 8'h40};
    logic [47:0] exp_q [$];
    int seed = 32'h2c3e;
    int n_mismatch = 0;
    int cmp_count = 0;
    always #50 clk_sys_i = ~clk_sys_i;
    wdx_core dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .media_present_i(pres), .media_wprot_i(wp),
        .media_change_i(chg), .media_chreq_i(creq), .dma_ultra_i(ultra), .sector_done_i(done),
        .xfer_cksum_err_i(ck), .xfer_udma_err_i(ue), .xfer_media_err_i(merr), .dev_fault_i(flt),
        .dma_run_o(run), .xfer_lba_o(lba), .xfer_count_o(cnt));
    wdx_dma_model u_dma (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .run_i(run), .gap_i(gap),
        .left_i(cnt), .fail_at_i(fail_at), .done_o(done), .fail_o(merr));
    // ----------------------------------------
    // Bus cycles and comparison
    // ----------------------------------------
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back({40'h0, e});
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] op);
        wr_reg(4'h7, op);
        repeat (3) @(posedge clk_sys_i);
    endtask
    task automatic print_verdict();
        $display("Mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk_sys_i) rd_q <= rd;
    always @(negedge clk_sys_i)
        if (rd_q)
            check({40'h0, rdata}, exp_q.pop_front());
    initial
    begin
        #4000000;
        n_mismatch++;
        print_verdict();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        repeat (10) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        rd_reg(4'h7, 8'h40);
        rd_reg(4'h1, 8'h00);
        for (int r = 0; r < 4; r++)
        begin
            for (int i = 0; i < 6; i++)
                b[i] = 8'($random(seed));
            c = (r == 3) ? 8'h00 : {6'h0, b[0][1:0]} + 8'h2;
            pv = '{{8'h0, c}, {b[3], b[2]}, {8'h0, b[4]}, {8'h0, b[5]}};
            for (int k = 0; k < 4; k++)
            begin
                wr_reg(4'(k + 2), pv[k][15:8]);
                wr_reg(4'(k + 2), pv[k][7:0]);
                wr_reg(4'h8, 8'h00);
                rd_reg(4'(k + 2), pv[k][7:0]);
                wr_reg(4'h8, 8'h80);
                rd_reg(4'(k + 2), pv[k][15:8]);
            end
            wr_reg(4'h6, 8'h40);
            gap <= 4'(r + 2);
            fail_at <= (r == 3) ? 17'hffff : 17'h0;
            cmd(8'h35);
            check({31'h0, cnt}, (r == 3) ? 48'h10000 : {40'h0, c});
            check(lba, {16'h0, b[3], b[5], b[4], b[2]});
            f = {16'h0, b[3], b[5], b[4], b[2]} + 48'h1;
            rd_reg(4'h7, 8'h80);
            for (int i = 0; i < 200 && run; i++)
                @(posedge clk_sys_i);
            check({47'h0, run}, 48'h0);
            if (r == 3)
                for (int k = 0; k < 3; k++)
                begin
                    wr_reg(4'h8, 8'h00);
                    rd_reg(4'(k + 3), f[8 * k +: 8]);
                    wr_reg(4'h8, 8'h80);
                    rd_reg(4'(k + 3), f[24 + 8 * k +: 8]);
                end
            else
                rd_reg(4'h7, 8'h40);
        end
        for (int e = 0; e < 8; e++)
        begin
            ultra <= (e != 7);
            wp <= (e == 1);
            pres <= (e != 2);
            creq <= (e == 3);
            chg <= (e == 4);
            @(posedge clk_sys_i);
            chg <= 1'b0;
            cmd((e == 0) ? 8'hca : 8'h35);
            ck <= (e == 5 || e == 7);
            ue <= (e == 6);
            flt <= (e == 6);
            @(posedge clk_sys_i);
            {ck, ue, flt} <= 3'h0;
            rd_reg(4'h1, errs[e]);
            rd_reg(4'h7, sts[e]);
            if (e == 3)
            begin
                creq <= 1'b0;
                cmd(8'hda);
                rd_reg(4'h7, 8'h40);
            end
        end
        wr_reg(4'h5, 8'h01);
        wr_reg(4'h5, 8'h00);
        cmd(8'h35);
        rd_reg(4'h1, 8'h10);
        wr_reg(4'h6, 8'h50);
        cmd(8'h35);
        check({47'h0, run}, 48'h0);
        rd_reg(4'h6, 8'h50);
        repeat (4) @(posedge clk_sys_i);
        print_verdict();
    end
endmodule
